// ==== hdl/upf_port.v ====
// What this block does
// - Readback keeps the old pipe while switching.
// - Data port accessed only while the ready flag reads 1.
// - Direction from pipe direction bit; pipe 0 from direction select.
// - DMA port auto-clear drops received data once read.
// - Buffer-valid ends writing and commits data.
// - Buffer-clear empties the buffer of the selected pipe.
// - Control register shows received length; mode bit picks readout.
// - Data in chosen byte order; rewind re-reads or rewrites.
// - Config bit 8 set enables continuous transfer.
// - Auto-NAK bit 7 set: a short-packet receive finish on pipe 0 sets control pipe NAK.
// - Short or zero-length packet finishes a receive transfer.
// - Response 00 answers every token with NAK.
`timescale 1ns/1ns
`default_nettype none
`include "upf_regs.vh"

module upf_port #(
    parameter PIPES    = 10,
    parameter DEPTH    = 16,
    parameter AW       = 4,
    parameter DMA_PORT = 1
) (
    input  wire               REF_CLK,
    input  wire               SYS_RST,
    input  wire [4:0]         AVS_ADDRESS,
    input  wire               AVS_READ,
    input  wire               AVS_WRITE,
    input  wire [31:0]        AVS_WRITEDATA,
    output reg  [31:0]        AVS_READDATA,
    output reg                AVS_WAITREQUEST,
    input  wire               USB_RX_VALID,
    input  wire [31:0]        USB_RX_DATA,
    output reg                USB_RX_READY,
    input  wire               USB_RX_END,
    input  wire               USB_RX_SHORT,
    input  wire [11:0]        USB_RX_LEN,
    output reg                USB_TX_VALID,
    output reg  [31:0]        USB_TX_DATA,
    input  wire               USB_TX_READY,
    output reg                USB_TX_COMMIT,
    input  wire               PIPE_BUSY,
    input  wire               SPLIT_STATUS,
    output reg  [PIPES-1:0]   PIPE_NAK,
    output reg                DMA_REQ,
    output reg  [3:0]         CUR_PIPE,
    output reg                CONT_MODE
);
    // ------------
    // State
    // ------------
    reg  [3:0]         new_pipe;
    reg  [3:0]         sw_cnt;
    reg                len_mode;
    reg                aclr;
    reg                dreq_en;
    reg                big;
    reg                dir_sel;
    reg  [1:0]         width;
    reg                anak;
    reg  [2*PIPES-1:0] resp;
    reg  [PIPES-1:0]   pdir;
    reg  [11:0]        rlen;
    reg                rx_done;
    reg  [31:0]        rd_mux;

    // ------------
    // Bus decode
    // ------------
    wire [4:0]  a       = {AVS_ADDRESS[4:2], 2'h0};
    wire        wr      = AVS_WRITE & ~AVS_WAITREQUEST;
    wire        rd      = AVS_READ & ~AVS_WAITREQUEST;
    wire [31:0] d       = AVS_WRITEDATA;
    wire        sel_wr  = wr && a == `UPF_SEL_OFS;
    wire        ctr_wr  = wr && a == `UPF_CTR_OFS;
    wire        data_wr = wr && a == `UPF_DATA_OFS;
    wire        data_rd = rd && a == `UPF_DATA_OFS;
    wire [3:0]  w_pipe  = d[`UPF_SEL_PIPE_LO +: 4];

    // ------------
    // Direction, readiness, FIFO hookup
    // ------------
    wire        switching = sw_cnt != 4'h0;
    // High: software writes the buffer and the link transmits it
    wire        tx_dir = (CUR_PIPE == 4'h0) ? dir_sel
                                            : pdir[CUR_PIPE];
    wire        f_in_ready;
    wire        f_out_valid;
    wire [31:0] f_out_data;
    wire [AW:0] f_count;
    wire        ready = ~switching &
                        (tx_dir ? f_in_ready : f_out_valid);
    wire        bus_push = data_wr & ready & tx_dir;
    wire        bus_pop  = data_rd & ready & ~tx_dir;
    wire        tx_take  = ~USB_TX_VALID | USB_TX_READY;
    wire        f_in_valid = tx_dir ? bus_push
                                    : (USB_RX_VALID & USB_RX_READY);
    wire        f_out_ready = tx_dir ? tx_take : bus_pop;
    wire        clr_req  = ctr_wr & d[`UPF_CTR_CLEAR];
    wire        commit   = ctr_wr & d[`UPF_CTR_VALID] & tx_dir;
    wire        sw_start = sel_wr & ~switching & w_pipe != CUR_PIPE &
                           w_pipe < PIPES;
    wire        aclr_fire = aclr & bus_pop & rx_done &
                            f_count == {{AW{1'b0}}, 1'b1};
    wire        flush  = clr_req | sw_start | aclr_fire;
    wire        rewind = sel_wr & d[`UPF_SEL_REWIND];
    wire        rx_end = USB_RX_END & ~tx_dir;
    wire [11:0] step = (width == `UPF_W8)  ? 12'h001 :
                       (width == `UPF_W16) ? 12'h002 : 12'h004;

    // Byte order applies within the selected access width
    function [31:0] swap;
        input [31:0] v;
        input [1:0]  w;
        input        b;
        begin
            if (!b)
                swap = v;
            else if (w == `UPF_W32)
                swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
            else if (w == `UPF_W16)
                swap = {16'h0000, v[7:0], v[15:8]};
            else
                swap = {24'h000000, v[7:0]};
        end
    endfunction

    upf_fifo #(
        .WIDTH (32),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst       (SYS_RST),
        .flush     (flush),
        .mark      (commit | rx_end),
        .rew_rd    (rewind & ~tx_dir),
        .rew_wr    (rewind & tx_dir),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (tx_dir ? swap(d, width, big) : USB_RX_DATA),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data),
        .count     (f_count)
    );

    // ------------
    // Read multiplexer
    // ------------
    always @* begin
        rd_mux = 32'h00000000;
        case (a)
            `UPF_SEL_OFS: begin
                rd_mux[`UPF_SEL_LRM]  = len_mode;
                rd_mux[`UPF_SEL_ACLR] = aclr;
                rd_mux[`UPF_SEL_DREQ] = dreq_en;
                rd_mux[`UPF_SEL_WID_LO +: 2] = width;
                rd_mux[`UPF_SEL_BIG]    = big;
                rd_mux[`UPF_SEL_DIRSEL] = dir_sel;
                // Old pipe stays visible until the switch completes
                rd_mux[`UPF_SEL_PIPE_LO +: 4] = CUR_PIPE;
            end
            `UPF_CTR_OFS: begin
                rd_mux[`UPF_CTR_READY] = ready;
                rd_mux[11:0] = rlen;
            end
            `UPF_DATA_OFS: begin
                if (ready && !tx_dir)
                    rd_mux = swap(f_out_data, width, big);
            end
            `UPF_CFG_OFS: begin
                rd_mux[`UPF_CFG_CONT] = CONT_MODE;
                rd_mux[`UPF_CFG_ANAK] = anak;
            end
            `UPF_RESP_OFS: begin
                rd_mux[2*PIPES-1:0]    = resp;
                rd_mux[`UPF_RESP_BUSY]  = PIPE_BUSY;
                rd_mux[`UPF_RESP_SPLIT] = SPLIT_STATUS;
            end
            `UPF_DIR_OFS: begin
                rd_mux[PIPES-1:0] = pdir;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // ------------
    // Bus handshake: one wait cycle per access
    // ------------
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
        end else begin
            AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
            if (AVS_READ && AVS_WAITREQUEST)
                AVS_READDATA <= rd_mux;
        end
    end

    // ------------
    // Configuration registers
    // ------------
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            len_mode  <= 1'b0;
            aclr      <= 1'b0;
            dreq_en   <= 1'b0;
            width     <= `UPF_W8;
            big       <= 1'b0;
            dir_sel   <= 1'b0;
            CONT_MODE <= 1'b0;
            anak      <= 1'b0;
            pdir      <= {PIPES{1'b0}};
        end else begin
            if (sel_wr) begin
                len_mode <= d[`UPF_SEL_LRM];
                aclr     <= d[`UPF_SEL_ACLR] & (DMA_PORT != 0);
                dreq_en  <= d[`UPF_SEL_DREQ] & (DMA_PORT != 0);
                width    <= d[`UPF_SEL_WID_LO +: 2];
                big      <= d[`UPF_SEL_BIG];
                dir_sel  <= d[`UPF_SEL_DIRSEL];
            end
            if (wr && a == `UPF_CFG_OFS) begin
                CONT_MODE <= d[`UPF_CFG_CONT];
                anak      <= d[`UPF_CFG_ANAK];
            end
            if (wr && a == `UPF_DIR_OFS)
                pdir <= d[PIPES-1:0];
        end
    end

    // ------------
    // Pipe switching
    // ------------
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            CUR_PIPE <= 4'h0;
            new_pipe <= 4'h0;
            sw_cnt   <= 4'h0;
        end else if (sw_start) begin
            new_pipe <= w_pipe;
            sw_cnt   <= `UPF_SWITCH_CYC;
        end else if (switching) begin
            sw_cnt <= sw_cnt - 4'h1;
            if (sw_cnt == 4'h1)
                CUR_PIPE <= new_pipe;
        end
    end

    // ------------
    // Received length and auto-clear tracking
    // ------------
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            rlen    <= `UPF_LEN_RST;
            rx_done <= 1'b0;
        end else begin
            if (flush) begin
                rlen    <= `UPF_LEN_RST;
                rx_done <= 1'b0;
            end else if (bus_pop && len_mode) begin
                rlen <= (rlen > step) ? rlen - step
                                      : `UPF_LEN_RST;
            end
            // Arrival beats a same-cycle clear
            if (rx_end) begin
                rlen    <= USB_RX_LEN;
                rx_done <= 1'b1;
            end
        end
    end

    // ------------
    // Pipe responses and NAK outputs
    // ------------
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            resp <= {PIPES{`UPF_RESP_NAK}};
        end else begin
            if (wr && a == `UPF_RESP_OFS)
                resp <= d[2*PIPES-1:0];
            // Hardware NAK wins over a same-cycle software write
            if (anak && rx_end && USB_RX_SHORT &&
                CUR_PIPE == 4'h0)
                resp[1:0] <= `UPF_RESP_NAK;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PIPES; g = g + 1) begin : g_nak
            always @(posedge REF_CLK) begin
                if (SYS_RST)
                    PIPE_NAK[g] <= 1'b1;
                else
                    PIPE_NAK[g] <= resp[2*g +: 2] == `UPF_RESP_NAK;
            end
        end
    endgenerate

    // ------------
    // Link side: transmit stage, receive ready, DMA
    // ------------
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            USB_TX_VALID  <= 1'b0;
            USB_TX_DATA   <= 32'h00000000;
            USB_TX_COMMIT <= 1'b0;
            USB_RX_READY  <= 1'b0;
            DMA_REQ       <= 1'b0;
        end else begin
            if (flush) begin
                USB_TX_VALID <= 1'b0;
            end else if (tx_dir && tx_take && f_out_valid) begin
                USB_TX_VALID <= 1'b1;
                USB_TX_DATA  <= f_out_data;
            end else if (USB_TX_READY) begin
                USB_TX_VALID <= 1'b0;
            end
            USB_TX_COMMIT <= commit;
            // Registered ready leaves one entry of slack
            USB_RX_READY  <= ~tx_dir & ~switching & ~flush &
                             f_count < DEPTH - 1;
            DMA_REQ <= dreq_en & CUR_PIPE != 4'h0 &
                       ready & ~flush;
        end
    end
endmodule
`default_nettype wire

// ==== shared/upf_regs.vh ====
`ifndef UPF_REGS_VH
`define UPF_REGS_VH
// ------------
// Register byte offsets
// ------------
`define UPF_SEL_OFS     5'h00
`define UPF_CTR_OFS     5'h04
`define UPF_DATA_OFS    5'h08
`define UPF_CFG_OFS     5'h0C
`define UPF_RESP_OFS    5'h10
`define UPF_DIR_OFS     5'h14
// ------------
// Port select register fields
// ------------
`define UPF_SEL_LRM     15
`define UPF_SEL_REWIND  14
`define UPF_SEL_ACLR    13
`define UPF_SEL_DREQ    12
`define UPF_SEL_WID_LO  10
`define UPF_SEL_BIG     8
`define UPF_SEL_DIRSEL  5
`define UPF_SEL_PIPE_LO 0
// ------------
// Port control register fields
// ------------
`define UPF_CTR_VALID   15
`define UPF_CTR_CLEAR   14
`define UPF_CTR_READY   13
// ------------
// Control pipe configuration and response
// ------------
`define UPF_CFG_CONT    8
`define UPF_CFG_ANAK    7
`define UPF_RESP_BUSY   31
`define UPF_RESP_SPLIT  30
`define UPF_RESP_NAK    2'h0
// ------------
// Widths, reset values, timing
// ------------
`define UPF_W8          2'h0
`define UPF_W16         2'h1
`define UPF_W32         2'h2
`define UPF_LEN_RST     12'h000
`define UPF_SWITCH_CYC  4'h4
`endif

// ==== hdl/upf_fifo.v ====
`timescale 1ns/1ns
`default_nettype none

module upf_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             flush,
    input  wire             mark,
    input  wire             rew_rd,
    input  wire             rew_wr,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      count
);
    // DEPTH must equal 2**AW; full is the carry bit of the count
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wp;
    reg [AW:0]      rp;
    reg [AW:0]      wb;
    reg [AW:0]      rb;

    assign count     = wp - rp;
    assign in_ready  = ~count[AW];
    assign out_valid = count != {(AW+1){1'b0}};
    assign out_data  = mem[rp[AW-1:0]];

    always @(posedge clk) begin
        if (rst || flush) begin
            wp <= {(AW+1){1'b0}};
            rp <= {(AW+1){1'b0}};
            wb <= {(AW+1){1'b0}};
            rb <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready)
                wp <= wp + 1'b1;
            if (out_valid && out_ready)
                rp <= rp + 1'b1;
            if (mark) begin
                wb <= wp;
                rb <= rp;
            end
            // Rewind wins over a same-cycle transfer
            if (rew_rd)
                rp <= rb;
            if (rew_wr)
                wp <= wb;
        end
    end

    always @(posedge clk) begin
        if (in_valid && in_ready)
            mem[wp[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// ==== tb/upf_port_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "upf_regs.vh"
module upf_mon #(
    parameter PIPES = 10
) (
    input wire logic             REF_CLK,
    input wire logic             SYS_RST,
    input wire logic [4:0]       AVS_ADDRESS,
    input wire logic             AVS_READ,
    input wire logic             AVS_WRITE,
    input wire logic [31:0]      AVS_WRITEDATA,
    input wire logic             AVS_WAITREQUEST,
    input wire logic             USB_RX_READY,
    input wire logic             USB_RX_END,
    input wire logic             USB_RX_SHORT,
    input wire logic             USB_TX_VALID,
    input wire logic [31:0]      USB_TX_DATA,
    input wire logic             USB_TX_READY,
    input wire logic [PIPES-1:0] PIPE_NAK,
    input wire logic             DMA_REQ,
    input wire logic [3:0]       CUR_PIPE,
    input wire logic             CONT_MODE
);
    // ----------------------------------------
    // Shadow of software-written fields
    // ----------------------------------------
    logic wr_ok, cont_h, anak_h, dreq_h, dir0_h;
    assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cont_h <= 1'b0;
            anak_h <= 1'b0;
            dreq_h <= 1'b0;
            dir0_h <= 1'b0;
        end else if (wr_ok && AVS_ADDRESS == `UPF_CFG_OFS) begin
            cont_h <= AVS_WRITEDATA[`UPF_CFG_CONT];
            anak_h <= AVS_WRITEDATA[`UPF_CFG_ANAK];
        end else if (wr_ok && AVS_ADDRESS == `UPF_SEL_OFS) begin
            dreq_h <= AVS_WRITEDATA[`UPF_SEL_DREQ];
            dir0_h <= AVS_WRITEDATA[`UPF_SEL_DIRSEL];
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_wait;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
            |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait low not exactly one cycle");
    property p_switch;
        wr_ok && AVS_ADDRESS == `UPF_SEL_OFS && AVS_WRITEDATA[3:0] < PIPES
            && AVS_WRITEDATA[3:0] != CUR_PIPE |-> ##2 !USB_RX_READY [*2];
    endproperty
    a_switch: assert property (p_switch)
        else $error("ready during pipe switch");
    property p_cont;
        wr_ok && AVS_ADDRESS == `UPF_CFG_OFS |-> ##2 (CONT_MODE == cont_h);
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous mode not following config");
    property p_nak_set;
        wr_ok && AVS_ADDRESS == `UPF_RESP_OFS && AVS_WRITEDATA[3:2] == 2'h0
            |-> ##2 PIPE_NAK[1];
    endproperty
    a_nak_set: assert property (p_nak_set)
        else $error("response 00 without nak");
    property p_nak_clr;
        wr_ok && AVS_ADDRESS == `UPF_RESP_OFS && AVS_WRITEDATA[3:2] != 2'h0
            |-> ##2 !PIPE_NAK[1];
    endproperty
    a_nak_clr: assert property (p_nak_clr)
        else $error("nak with nonzero response");
    property p_anak;
        anak_h && CUR_PIPE == 4'h0 && !dir0_h && USB_RX_END && USB_RX_SHORT
            |-> ##[1:2] PIPE_NAK[0];
    endproperty
    a_anak: assert property (p_anak)
        else $error("no auto nak after short packet");
    property p_dma;
        DMA_REQ |-> $past(dreq_h) && $past(CUR_PIPE) != 4'h0;
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma request without enable or on pipe 0");
    property p_tx_hold;
        USB_TX_VALID && !USB_TX_READY |=> USB_TX_VALID && $stable(USB_TX_DATA);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit word dropped while stalled");
endmodule
bind upf_port upf_mon #(.PIPES(PIPES)) u_mon (
    .REF_CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_WAITREQUEST, .USB_RX_READY, .USB_RX_END,
    .USB_RX_SHORT, .USB_TX_VALID, .USB_TX_DATA, .USB_TX_READY,
    .PIPE_NAK, .DMA_REQ, .CUR_PIPE, .CONT_MODE
);
`default_nettype wire

// ==== tb/upf_usb_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module upf_usb_model (
    input  wire logic        clk,
    input  wire logic        stall,
    output var  logic        rx_valid,
    output var  logic [31:0] rx_data,
    input  wire logic        rx_ready,
    output var  logic        rx_end,
    output var  logic        rx_short,
    output var  logic [11:0] rx_len,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_data,
    output var  logic        tx_ready
);
    logic [31:0] txq[$];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 32'h0;
        rx_end   = 1'b0;
        rx_short = 1'b0;
        rx_len   = 12'h000;
        tx_ready = 1'b0;
    end
    // ----------------------------------------
    // Packet engine: every packet ends short
    // ----------------------------------------
    task automatic send(input int n, input logic [31:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data  <= base + i;
            do @(posedge clk); while (rx_ready !== 1'b1);
            rx_valid <= 1'b0;
            rx_data  <= ~(base + i); // Idle bus must not look like data
        end
        rx_end   <= 1'b1;
        rx_short <= 1'b1;
        rx_len   <= 12'(n * 4);
        @(posedge clk);
        rx_end   <= 1'b0;
        rx_short <= 1'b0;
    endtask
    always @(posedge clk) begin
        tx_ready <= !stall;
        if (tx_valid && tx_ready)
            txq.push_back(tx_data);
    end
endmodule
`default_nettype wire

// ==== tb/usb_pipe_fifo_port_access_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "upf_regs.vh"
module usb_pipe_fifo_port_access_bench;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] W32 = 32'h0000_0800;
    logic        REF_CLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
    logic [4:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, USB_RX_DATA, USB_TX_DATA, rdat;
    logic        USB_RX_VALID, USB_RX_READY, USB_RX_END, USB_RX_SHORT;
    logic [11:0] USB_RX_LEN;
    logic        USB_TX_VALID, USB_TX_READY, USB_TX_COMMIT, PIPE_BUSY;
    logic        SPLIT_STATUS, DMA_REQ, CONT_MODE, stall;
    logic [9:0]  PIPE_NAK;
    logic [3:0]  CUR_PIPE;
    int          mismatches, checks_done, commits, dmas;
    upf_port #(.PIPES(10), .DEPTH(16), .AW(4), .DMA_PORT(1)) DUT (
        .REF_CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .USB_RX_VALID,
        .USB_RX_DATA, .USB_RX_READY, .USB_RX_END, .USB_RX_SHORT,
        .USB_RX_LEN, .USB_TX_VALID, .USB_TX_DATA, .USB_TX_READY,
        .USB_TX_COMMIT, .PIPE_BUSY, .SPLIT_STATUS, .PIPE_NAK, .DMA_REQ,
        .CUR_PIPE, .CONT_MODE
    );
    upf_usb_model u_usb (
        .clk(REF_CLK), .stall(stall), .rx_valid(USB_RX_VALID),
        .rx_data(USB_RX_DATA), .rx_ready(USB_RX_READY), .rx_end(USB_RX_END),
        .rx_short(USB_RX_SHORT), .rx_len(USB_RX_LEN),
        .tx_valid(USB_TX_VALID), .tx_data(USB_TX_DATA),
        .tx_ready(USB_TX_READY)
    );
    initial begin
        REF_CLK = 1'b0;
        forever #50 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        if (USB_TX_COMMIT === 1'b1)
            commits++;
        if (DMA_REQ === 1'b1)
            dmas++;
    end
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= w;
        AVS_READ      <= !w;
        do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
        rdat = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] m, e);
        bus(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask
    task automatic sel(input logic [31:0] v);
        int n;
        wr(`UPF_SEL_OFS, v);
        n = 0;
        do begin
            bus(1'b0, `UPF_SEL_OFS, 32'h0);
            n++;
        end while (rdat[3:0] !== v[3:0] && n < 20);
        chk(rdat[3:0], v[3:0]);
        chk(CUR_PIPE, v[3:0]);
    endtask
    task automatic txwait(input int n);
        for (int i = 0; i < 40 && u_usb.txq.size() < n; i++)
            @(posedge REF_CLK);
        chk(u_usb.txq.size(), n);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk(PIPE_NAK, 32'h3FF);
        rd(`UPF_CFG_OFS, ALL, 32'h0);
        rd(`UPF_RESP_OFS, 32'h000F_FFFF, 32'h0);
        wr(5'h18, ALL);
        rd(5'h18, ALL, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_receive;
        sel(W32 | 32'h1);
        u_usb.send(2, 32'hA1B2_C3D0);
        rd(`UPF_CTR_OFS, 32'h2FFF, 32'h2008);
        rd(`UPF_DATA_OFS, ALL, 32'hA1B2_C3D0);
        sel(W32 | 32'h4000 | 32'h1);
        rd(`UPF_DATA_OFS, ALL, 32'hA1B2_C3D0);
        rd(`UPF_DATA_OFS, ALL, 32'hA1B2_C3D1);
        rd(`UPF_CTR_OFS, 32'h0FFF, 32'h8);
        rd(`UPF_DATA_OFS, ALL, 32'h0);
        wr(`UPF_CTR_OFS, 32'h4000);
        rd(`UPF_CTR_OFS, 32'h0FFF, 32'h0);
        $display("test receive done");
    endtask
    task automatic t_count;
        sel(W32 | 32'h8000 | 32'h100 | 32'h1);
        u_usb.send(2, 32'h1122_3344);
        rd(`UPF_CTR_OFS, 32'h0FFF, 32'h8);
        rd(`UPF_DATA_OFS, ALL, 32'h4433_2211);
        rd(`UPF_CTR_OFS, 32'h0FFF, 32'h4);
        sel(32'h0400 | 32'h8000 | 32'h100 | 32'h1);
        rd(`UPF_DATA_OFS, ALL, 32'h0000_4533);
        rd(`UPF_CTR_OFS, 32'h0FFF, 32'h2);
        sel(W32 | 32'h2000 | 32'h1);
        u_usb.send(1, 32'h77);
        rd(`UPF_DATA_OFS, ALL, 32'h77);
        rd(`UPF_CTR_OFS, 32'h0FFF, 32'h0);
        $display("test count done");
    endtask
    task automatic t_transmit;
        stall <= 1'b1;
        wr(`UPF_DIR_OFS, 32'h4);
        sel(W32 | 32'h2);
        chk(USB_RX_READY, 1'b0);
        for (int i = 0; i < 3; i++)
            wr(`UPF_DATA_OFS, 32'hD00 + i);
        commits = 0;
        wr(`UPF_CTR_OFS, 32'h8000);
        chk(USB_TX_VALID, 1'b1);
        stall <= 1'b0;
        txwait(3);
        chk(commits, 1);
        for (int i = 0; i < 3; i++)
            chk(u_usb.txq[i], 32'hD00 + i);
        sel(W32 | 32'h20);
        wr(`UPF_DATA_OFS, 32'hC0DE);
        txwait(4);
        chk(u_usb.txq[3], 32'hC0DE);
        $display("test transmit done");
    endtask
    task automatic t_fill;
        sel(W32 | 32'h1);
        fork
            u_usb.send(16, 32'h100);
        join_none
        repeat (60) @(posedge REF_CLK);
        chk(USB_RX_READY, 1'b0);
        for (int i = 0; i < 16; i++) begin
            if (i == 15)
                wait fork;
            rd(`UPF_DATA_OFS, ALL, 32'h100 + i);
        end
        rd(`UPF_DATA_OFS, ALL, 32'h0);
        wr(`UPF_CTR_OFS, 32'h4000);
        $display("test fill done");
    endtask
    task automatic t_autonak;
        sel(W32);
        PIPE_BUSY <= 1'b1;
        rd(`UPF_RESP_OFS, 32'hC000_0000, 32'h8000_0000);
        PIPE_BUSY    <= 1'b0;
        SPLIT_STATUS <= 1'b1;
        rd(`UPF_RESP_OFS, 32'hC000_0000, 32'h4000_0000);
        SPLIT_STATUS <= 1'b0;
        wr(`UPF_CFG_OFS, 32'h180);
        rd(`UPF_CFG_OFS, ALL, 32'h180);
        chk(CONT_MODE, 1'b1);
        wr(`UPF_RESP_OFS, 32'h5);
        rd(`UPF_RESP_OFS, 32'hF, 32'h5);
        chk(PIPE_NAK[1:0], 2'h0);
        u_usb.send(1, 32'h5);
        rd(`UPF_RESP_OFS, 32'h3, 32'h0);
        chk(PIPE_NAK[0], 1'b1);
        wr(`UPF_CFG_OFS, 32'h0);
        wr(`UPF_CTR_OFS, 32'h4000);
        chk(CONT_MODE, 1'b0);
        wr(`UPF_RESP_OFS, 32'h1);
        u_usb.send(1, 32'h6);
        rd(`UPF_RESP_OFS, 32'h3, 32'h1);
        wr(`UPF_RESP_OFS, 32'h0);
        rd(`UPF_RESP_OFS, 32'hF, 32'h0);
        chk(PIPE_NAK, 32'h3FF);
        $display("test autonak done");
    endtask
    task automatic t_dma;
        wr(`UPF_CTR_OFS, 32'h4000);
        dmas = 0;
        sel(W32 | 32'h1000);
        u_usb.send(1, 32'h7);
        rd(`UPF_CTR_OFS, 32'h0FFF, 32'h4);
        chk(dmas, 0);
        wr(`UPF_CTR_OFS, 32'h4000);
        sel(W32 | 32'h1000 | 32'h1);
        u_usb.send(1, 32'h8);
        rd(`UPF_DATA_OFS, ALL, 32'h8);
        chk(dmas != 0, 1'b1);
        sel(W32 | 32'h1);
        $display("test dma done");
    endtask
    // ----------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        SYS_RST = 1'b1;
        AVS_ADDRESS = 5'h00;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = 32'h0;
        PIPE_BUSY = 1'b0;
        SPLIT_STATUS = 1'b0;
        stall = 1'b0;
        repeat (5) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        t_reset;
        t_receive;
        t_count;
        t_transmit;
        t_fill;
        t_autonak;
        t_dma;
        test_done;
    end
    initial begin
        #3000000; // Tests need a few thousand cycles at most
        mismatches++;
        test_done;
    end
endmodule
`default_nettype wire
